// ---- core/cipr_regs.sv ----
/*
 Interrupt mask, read-to-clear flag, protection enable, switch control and
 converter control registers of a direct battery-charging switch.
 Assumes a register port (address, write strobe, read strobe, data) driven
 by the serial slave, and comparator/loop status levels synchronous to clk.
*/
// Functional notes
// [RULE1] All fields default on reset, soft reset, watchdog
// [RULE2] Flags set by event, held, cleared by read
// [RULE3] Conversion-done flag only in single-shot mode
// [RULE4] Over-temperature flags need thermistor channel enabled
// [RULE5] Insertion flags on both edges, ADC enabled
// [RULE6] Regulation flags set while loop limits switch
// [RULE7] Separate fault flags for each protection fault
// [RULE8] Reverse-current flag above selected threshold
// [RULE9] Reverse threshold: 0 is 100 mA, else 3000
// [RULE10] Protection enables default all on except pull-down
// [RULE11] Pull-down enable connects input pull-down, default 0
// [RULE12] Drop overvoltage opens switch after deglitch when enabled
// [RULE13] Drop alarm flags host without opening switch
// [RULE14] Host programs shunt select to match resistor
// [RULE15] Pass enable self-clears on fault except undervoltage
// [RULE16] Watchdog off, 0.5, 1.0, 2.0 s; default 10
// [RULE17] Writing 1 to soft reset defaults; self-clears
// [RULE18] Die temperature measurement enable defaults to 1
// [RULE19] Converter master enable default 0; mode default 1
// [RULE20] Reserved bits ignore writes, read 0
// [RULE21] Mode bit: 0 single conversion, 1 continuous
// [RULE22] Interrupt low while any unmasked flag set
`timescale 1ns/1ps
`include "cipr_defs.svh"

module cipr_regs #(
  parameter int unsigned WDT_UNIT_CYCLES = `CIPR_CLK_HZ / 1000 * `CIPR_WDT_UNIT_MS // Half second
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic resetn, // Async reset, low
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata_ff, // Read data
  input wire logic input_ov_det, // Input overvoltage comparator
  input wire logic input_cc_act, // Input current loop limiting
  input wire logic batt_cv_act, // Battery voltage loop limiting
  input wire logic batt_cc_act, // Battery current loop limiting
  input wire logic output_cv_act, // Output voltage loop limiting
  input wire logic conn_hot, // Connector thermistor over limit
  input wire logic batt_hot, // Battery thermistor over limit
  input wire logic reverse_det, // Reverse current over selected limit
  input wire logic conv_done, // Converter finished a conversion
  input wire logic drop_alarm_det, // Drop over alarm threshold
  input wire logic drop_ov_det, // Drop over limit past deglitch
  input wire logic input_insert_cmp, // Input presence comparator
  input wire logic batt_insert_cmp, // Battery presence comparator
  input wire logic die_hot, // Die over shutdown limit
  input wire logic input_oc_det, // Input overcurrent fault
  input wire logic uvlo_open, // Switch opened by undervoltage
  input wire logic conn_chan_en, // Connector thermistor channel on
  input wire logic batt_chan_en, // Battery thermistor channel on
  output logic irq_n_o, // Interrupt pin drive value
  output logic irq_n_oe, // Interrupt pin enable, high drives low
  output logic switch_close, // Close pass switch
  output logic pulldown_on, // Input pull-down connect
  output logic [7:0] prot_enables, // Protection enables
  output logic shunt_value_sel, // Sense resistor select
  output logic reverse_threshold_sel, // Reverse threshold select
  output logic [15:0] reverse_limit_ma, // Reverse threshold in mA
  output logic die_temp_meas_enable, // Die temperature measured
  output logic adc_enable, // Converter master enable
  output logic adc_continuous // Continuous conversion mode
);
  logic [7:0] mask_a_ff, mask_b_ff, prot_en_ff, sw_ctrl_ff, conv_ctrl_ff;
  logic [7:0] nxt_mask_a, nxt_mask_b, nxt_prot_en, nxt_sw_ctrl, nxt_conv_ctrl, nxt_rdata;
  logic ins_in_ff, ins_bat_ff, nxt_ins_in, nxt_ins_bat;
  logic soft_rst, wdt_expire, fault_open, drop_ov_fault, drop_alarm_ev;
  logic [7:0] flags_a_ff, flags_b_ff, evt_a, evt_b;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------
  // Event gating
  // ----------------------------------------
  // [RULE12] Drop fault when enabled
  assign drop_ov_fault = drop_ov_det & sw_ctrl_ff[`CIPR_SW_DROP_OV_EN];
  // [RULE13] Alarm flags only
  assign drop_alarm_ev = drop_alarm_det & sw_ctrl_ff[`CIPR_SW_DROP_ALM_EN];

  always_comb
  begin
    // Input overvoltage event, then [RULE6] regulation loop events
    evt_a[7] = input_ov_det;
    evt_a[6] = input_cc_act;
    evt_a[5] = batt_cv_act;
    evt_a[4] = batt_cc_act;
    evt_a[3] = output_cv_act;
    // [RULE4] Channel gates over-temperature
    evt_a[2] = conn_hot & conn_chan_en;
    evt_a[1] = batt_hot & batt_chan_en;
    // [RULE8] Reverse current event
    evt_a[0] = reverse_det;
    evt_b[7] = 1'b0;
    // [RULE3] Single-shot only
    evt_b[6] = conv_done & ~conv_ctrl_ff[`CIPR_CC_CONT_MODE];
    // [RULE7] Separate fault events
    evt_b[5] = drop_alarm_ev;
    evt_b[4] = drop_ov_fault;
    // [RULE5] Either edge, converter on
    evt_b[3] = adc_enable & (input_insert_cmp ^ ins_in_ff);
    evt_b[2] = adc_enable & (batt_insert_cmp ^ ins_bat_ff);
    evt_b[1] = die_hot;
    evt_b[0] = input_oc_det;
  end

  // Faults that open the switch; undervoltage deliberately excluded
  assign fault_open = input_ov_det | die_hot | input_oc_det | drop_ov_fault | reverse_det
    | evt_a[2] | evt_a[1];

  // ----------------------------------------
  // Flag registers and watchdog
  // ----------------------------------------
  // [RULE2] Read clears flags
  cipr_flag_cell u_flags_a (
    .clk(clk),
    .resetn(resetn),
    .soft_clr(soft_rst),
    .evt(evt_a),
    .rd_clr(reg_rd & hit(reg_addr, `CIPR_OFS_FLAGS_A)),
    .flags_ff(flags_a_ff)
  );

  cipr_flag_cell u_flags_b (
    .clk(clk),
    .resetn(resetn),
    .soft_clr(soft_rst),
    .evt(evt_b & `CIPR_WMASK_FLAGS_B),
    .rd_clr(reg_rd & hit(reg_addr, `CIPR_OFS_FLAGS_B)),
    .flags_ff(flags_b_ff)
  );

  // [RULE16] Period from switch control
  cipr_watchdog #(.UNIT_CYCLES(WDT_UNIT_CYCLES)) u_wdt (
    .clk(clk),
    .resetn(resetn),
    .kick(reg_wr | reg_rd),
    .period(sw_ctrl_ff[`CIPR_SW_WDT_HI:`CIPR_SW_WDT_LO]),
    .expire(wdt_expire)
  );

  // [RULE17] Self-clearing soft reset
  assign soft_rst = sw_ctrl_ff[`CIPR_SW_SOFT_RST] | wdt_expire;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_comb
  begin
    nxt_mask_a = mask_a_ff;
    nxt_mask_b = mask_b_ff;
    nxt_prot_en = prot_en_ff;
    nxt_sw_ctrl = sw_ctrl_ff;
    nxt_conv_ctrl = conv_ctrl_ff;
    nxt_ins_in = input_insert_cmp;
    nxt_ins_bat = batt_insert_cmp;
    // [RULE1] Soft reset and watchdog default all
    if (soft_rst)
    begin
      nxt_mask_a = `CIPR_RST_MASK_A;
      nxt_mask_b = `CIPR_RST_MASK_B;
      nxt_prot_en = `CIPR_RST_PROT_EN;
      nxt_sw_ctrl = `CIPR_RST_SW_CTRL;
      nxt_conv_ctrl = `CIPR_RST_CONV_CTRL;
    end
    else
    begin
      if (reg_wr)
      begin
        if (hit(reg_addr, `CIPR_OFS_MASK_A))
        begin
          nxt_mask_a = reg_wdata;
        end
        // [RULE20] Reserved bits stay zero
        if (hit(reg_addr, `CIPR_OFS_MASK_B))
        begin
          nxt_mask_b = reg_wdata & `CIPR_WMASK_MASK_B;
        end
        if (hit(reg_addr, `CIPR_OFS_PROT_EN))
        begin
          nxt_prot_en = reg_wdata;
        end
        if (hit(reg_addr, `CIPR_OFS_SW_CTRL))
        begin
          nxt_sw_ctrl = reg_wdata;
        end
        if (hit(reg_addr, `CIPR_OFS_CONV_CTRL))
        begin
          nxt_conv_ctrl = reg_wdata & `CIPR_WMASK_CONV_CTRL;
        end
      end
      // [RULE15] Fault opens, enable drops
      if (fault_open && !uvlo_open)
      begin
        nxt_sw_ctrl[`CIPR_SW_PASS_EN] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mask_a_ff <= `CIPR_RST_MASK_A;
      mask_b_ff <= `CIPR_RST_MASK_B;
      // [RULE10] All on except pull-down
      prot_en_ff <= `CIPR_RST_PROT_EN;
      sw_ctrl_ff <= `CIPR_RST_SW_CTRL;
      conv_ctrl_ff <= `CIPR_RST_CONV_CTRL;
      ins_in_ff <= 1'b0;
      ins_bat_ff <= 1'b0;
    end
    else
    begin
      mask_a_ff <= nxt_mask_a;
      mask_b_ff <= nxt_mask_b;
      prot_en_ff <= nxt_prot_en;
      sw_ctrl_ff <= nxt_sw_ctrl;
      conv_ctrl_ff <= nxt_conv_ctrl;
      ins_in_ff <= nxt_ins_in;
      ins_bat_ff <= nxt_ins_bat;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb
  begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd)
    begin
      case (reg_addr)
        `CIPR_OFS_MASK_A: nxt_rdata = mask_a_ff;
        `CIPR_OFS_MASK_B: nxt_rdata = mask_b_ff;
        `CIPR_OFS_FLAGS_A: nxt_rdata = flags_a_ff;
        `CIPR_OFS_FLAGS_B: nxt_rdata = flags_b_ff;
        `CIPR_OFS_PROT_EN: nxt_rdata = prot_en_ff;
        // Soft reset bit never visible set
        `CIPR_OFS_SW_CTRL: nxt_rdata = sw_ctrl_ff & 8'hFE;
        `CIPR_OFS_CONV_CTRL: nxt_rdata = conv_ctrl_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata_ff <= 8'h00;
    end
    else
    begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // [RULE22] Unmasked flag pulls low
  assign irq_n_oe = |((flags_a_ff & ~mask_a_ff) | (flags_b_ff & ~mask_b_ff));
  assign irq_n_o = 1'b0;
  assign switch_close = sw_ctrl_ff[`CIPR_SW_PASS_EN];
  // [RULE11] Pull-down connect
  assign pulldown_on = prot_en_ff[`CIPR_PE_PULLDOWN];
  assign prot_enables = prot_en_ff;
  // [RULE14] Shunt select passed through
  assign shunt_value_sel = sw_ctrl_ff[`CIPR_SW_SHUNT_SEL];
  assign reverse_threshold_sel = sw_ctrl_ff[`CIPR_SW_RCB_SEL];
  // [RULE9] Threshold in mA
  assign reverse_limit_ma = reverse_threshold_sel ? 16'(`CIPR_RCB_HIGH_MA)
    : 16'(`CIPR_RCB_LOW_MA);
  // [RULE18] Die temperature measured
  assign die_temp_meas_enable = conv_ctrl_ff[`CIPR_CC_DIE_TEMP_EN];
  // [RULE19] Converter enable and mode
  assign adc_enable = conv_ctrl_ff[`CIPR_CC_ADC_EN];
  // [RULE21] One means continuous
  assign adc_continuous = conv_ctrl_ff[`CIPR_CC_CONT_MODE];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SOFT_RST_DEFAULTS: assert property (@(posedge clk) disable iff (!resetn) // [RULE1]
    soft_rst |=> (prot_en_ff == `CIPR_RST_PROT_EN && mask_a_ff == 8'h00
      && conv_ctrl_ff == `CIPR_RST_CONV_CTRL))
    else $error("soft reset did not restore defaults");
  AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
    (flags_a_ff[0] && !reg_rd && !soft_rst) |=> flags_a_ff[0])
    else $error("flag dropped without read");
  AST_READ_CLEARS: assert property (@(posedge clk) disable iff (!resetn) // [RULE2]
    (reg_rd && reg_addr == `CIPR_OFS_FLAGS_A && evt_a == 8'h00) |=> flags_a_ff == 8'h00)
    else $error("read did not clear flags");
  AST_DONE_CONT: assert property (@(posedge clk) disable iff (!resetn) // [RULE3]
    (adc_continuous && $stable(adc_continuous) && !flags_b_ff[6]) |=> !flags_b_ff[6]
      || $past(conv_ctrl_ff[`CIPR_CC_CONT_MODE]) == 1'b0)
    else $error("done flag set in continuous mode");
  AST_OT_GATED: assert property (@(posedge clk) disable iff (!resetn) // [RULE4]
    (!conn_chan_en && !flags_a_ff[2] && !soft_rst) |=> !flags_a_ff[2])
    else $error("over-temperature flag without channel");
  AST_INSERT_EDGE: assert property (@(posedge clk) disable iff (!resetn) // [RULE5]
    (adc_enable && input_insert_cmp != ins_in_ff && !soft_rst) |=> flags_b_ff[3])
    else $error("insertion edge not flagged");
  AST_PASS_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // [RULE15]
    (fault_open && !uvlo_open) |=> !switch_close)
    else $error("pass enable kept after fault");
  AST_SOFT_SELF_CLEAR: assert property (@(posedge clk) disable iff (!resetn) // [RULE17]
    sw_ctrl_ff[`CIPR_SW_SOFT_RST] |=> !sw_ctrl_ff[`CIPR_SW_SOFT_RST])
    else $error("soft reset bit stuck");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!resetn) // [RULE20]
    (mask_b_ff[7] == 1'b0 && conv_ctrl_ff[6:4] == 3'b000))
    else $error("reserved bit set");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!resetn) // [RULE22]
    (flags_b_ff[1] && !mask_b_ff[1]) |-> irq_n_oe)
    else $error("unmasked flag not signalled");
  COV_FAULT_OPEN: cover property (@(posedge clk) disable iff (!resetn)
    switch_close ##1 !switch_close);
  COV_READ_CLEAR: cover property (@(posedge clk) disable iff (!resetn)
    flags_b_ff[0] ##1 (reg_rd && reg_addr == `CIPR_OFS_FLAGS_B));
  COV_SOFT_RST: cover property (@(posedge clk) disable iff (!resetn) soft_rst);
  COV_WDT: cover property (@(posedge clk) disable iff (!resetn) wdt_expire);
endmodule

// ---- core/cipr_defs.svh ----
/*
 Register offsets, field positions, reset values and timing counts of the
 charger interrupt and protection register bank.
 Assumes inclusion by bare name from the package and the modules.
*/
`ifndef CIPR_DEFS_SVH
`define CIPR_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CIPR_OFS_MASK_A 8'h01
`define CIPR_OFS_MASK_B 8'h02
`define CIPR_OFS_FLAGS_A 8'h03
`define CIPR_OFS_FLAGS_B 8'h04
`define CIPR_OFS_PROT_EN 8'h05
`define CIPR_OFS_SW_CTRL 8'h06
`define CIPR_OFS_CONV_CTRL 8'h07

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIPR_RST_MASK_A 8'h00
`define CIPR_RST_MASK_B 8'h00
`define CIPR_RST_FLAGS 8'h00
`define CIPR_RST_PROT_EN 8'hFE
`define CIPR_RST_SW_CTRL 8'h28
`define CIPR_RST_CONV_CTRL 8'h87

// ----------------------------------------
// Writable bits per register
// ----------------------------------------
`define CIPR_WMASK_MASK_B 8'h7F
`define CIPR_WMASK_FLAGS_B 8'h7F
`define CIPR_WMASK_CONV_CTRL 8'h8F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CIPR_SW_DROP_OV_EN 7
`define CIPR_SW_DROP_ALM_EN 6
`define CIPR_SW_SHUNT_SEL 5
`define CIPR_SW_PASS_EN 4
`define CIPR_SW_WDT_HI 3
`define CIPR_SW_WDT_LO 2
`define CIPR_SW_RCB_SEL 1
`define CIPR_SW_SOFT_RST 0
`define CIPR_CC_DIE_TEMP_EN 7
`define CIPR_CC_ADC_EN 3
`define CIPR_CC_CONT_MODE 2
`define CIPR_PE_PULLDOWN 0
`define CIPR_PE_CONN_OT_EN 2
`define CIPR_PE_BATT_OT_EN 1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CIPR_CLK_HZ 20000000
`define CIPR_WDT_UNIT_MS 500
`define CIPR_RCB_LOW_MA 100
`define CIPR_RCB_HIGH_MA 3000

`endif

// ---- core/cipr_pkg.sv ----
/*
 Types of the charger interrupt and protection register bank.
 Assumes cipr_defs.svh is on the include path.
*/
`include "cipr_defs.svh"

package cipr_pkg;
  // Watchdog period codes
  typedef enum logic [1:0] {
    CIPR_WDT_OFF = 2'b00,
    CIPR_WDT_HALF = 2'b01,
    CIPR_WDT_ONE = 2'b10,
    CIPR_WDT_TWO = 2'b11
  } cipr_wdt_type;

  // Watchdog timer states
  typedef enum logic [1:0] {
    CIPR_WS_IDLE = 2'b00,
    CIPR_WS_RUN = 2'b01,
    CIPR_WS_FIRE = 2'b10
  } cipr_wstate_type;
endpackage

// ---- core/cipr_flag_cell.sv ----
/*
 One eight-bit read-to-clear flag register.
 Assumes events are pulses or levels sync to clk; the read strobe is one cycle.
*/
`timescale 1ns/1ps
`include "cipr_defs.svh"

module cipr_flag_cell (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, low
  input wire logic soft_clr, // Return to default
  input wire logic [7:0] evt, // Hardware set requests
  input wire logic rd_clr, // Register read strobe
  output logic [7:0] flags_ff // Sticky flags
);
  logic [7:0] nxt_flags;

  // Set wins over the clearing read so no event is lost
  always_comb
  begin
    nxt_flags = flags_ff;
    if (soft_clr)
    begin
      nxt_flags = `CIPR_RST_FLAGS;
    end
    else
    begin
      if (rd_clr)
      begin
        nxt_flags = `CIPR_RST_FLAGS;
      end
      nxt_flags = nxt_flags | evt;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flags_ff <= 8'h00;
    end
    else
    begin
      flags_ff <= nxt_flags;
    end
  end
endmodule

// ---- core/cipr_watchdog.sv ----
/*
 Register watchdog: restarts on each host access, fires after the period.
 Assumes one clk domain; period code from the switch control register.
*/
`timescale 1ns/1ps
`include "cipr_defs.svh"

module cipr_watchdog #(
  parameter int unsigned UNIT_CYCLES = `CIPR_CLK_HZ / 1000 * `CIPR_WDT_UNIT_MS
) (
  input wire logic clk, // System clock
  input wire logic resetn, // Async reset, low
  input wire logic kick, // Host access restarts count
  input wire logic [1:0] period, // Period code
  output logic expire // One-cycle expiry pulse
);
  cipr_pkg::cipr_wstate_type state_ff;
  cipr_pkg::cipr_wstate_type nxt_state;
  logic [26:0] cnt_ff;
  logic [26:0] nxt_cnt;
  logic [26:0] limit;

  function automatic logic [26:0] wdt_limit(input logic [1:0] code);
    case (code)
      2'b01: wdt_limit = 27'(UNIT_CYCLES - 1);
      2'b10: wdt_limit = 27'(2 * UNIT_CYCLES - 1);
      default: wdt_limit = 27'(4 * UNIT_CYCLES - 1);
    endcase
  endfunction

  assign limit = wdt_limit(period);
  assign expire = (state_ff == cipr_pkg::CIPR_WS_FIRE);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      cipr_pkg::CIPR_WS_IDLE:
      begin
        nxt_cnt = 27'h0;
        if (period != cipr_pkg::CIPR_WDT_OFF)
        begin
          nxt_state = cipr_pkg::CIPR_WS_RUN;
        end
      end
      cipr_pkg::CIPR_WS_RUN:
      begin
        if (period == cipr_pkg::CIPR_WDT_OFF || kick)
        begin
          nxt_cnt = 27'h0;
          if (period == cipr_pkg::CIPR_WDT_OFF)
          begin
            nxt_state = cipr_pkg::CIPR_WS_IDLE;
          end
        end
        else if (cnt_ff >= limit)
        begin
          nxt_state = cipr_pkg::CIPR_WS_FIRE;
        end
        else
        begin
          nxt_cnt = cnt_ff + 27'h1;
        end
      end
      default:
      begin
        nxt_state = cipr_pkg::CIPR_WS_IDLE;
        nxt_cnt = 27'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_ff <= cipr_pkg::CIPR_WS_IDLE;
      cnt_ff <= 27'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  AST_WDT_PULSE_ONE: assert property (@(posedge clk) disable iff (!resetn)
    expire |=> !expire)
    else $error("watchdog expiry longer than one cycle");
endmodule

// ---- testbench/cipr_host_model.sv ----
/*
 Host side of the register port: single register writes and reads.
 Assumes the bank takes a request on the rising edge where its strobe is high.
*/
`timescale 1ns/1ps

module cipr_host_model (
  input wire logic clk, // System clock
  output logic [7:0] reg_addr, // Register address
  output logic reg_wr, // Write strobe
  output logic [7:0] reg_wdata, // Write data
  output logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata_ff // Read data
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Released lines flip so stale values are never mistaken for live ones
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata_ff;
  endtask
endmodule

// ---- testbench/charger_irq_protect_regs_tb_top.sv ----
/*
 Self-checking bench of the charger interrupt and protection register bank.
 Assumes the host model drives the register port; the bench drives status levels.
*/
`timescale 1ns/1ps

module charger_irq_protect_regs_tb_top;
  // Short unit keeps the period codes testable in a few hundred cycles
  localparam int WD_UNIT = 50;
  logic clk;
  logic resetn;
  logic [7:0] ev_a;
  logic [7:0] ev_b;
  logic uvlo_open;
  logic conn_chan_en;
  logic batt_chan_en;
  logic irq_n_o;
  logic [7:0] prot_enables;
  logic reverse_threshold_sel;
  logic [7:0] reg_addr;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic reg_rd;
  logic [7:0] reg_rdata_ff;
  logic irq_n_oe;
  logic switch_close;
  logic pulldown_on;
  logic shunt_value_sel;
  logic [15:0] reverse_limit_ma;
  logic die_temp_meas_enable;
  logic adc_enable;
  logic adc_continuous;
  int errors = 0;
  int samples_checked = 0;

  cipr_host_model cipr_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff));

  cipr_regs #(.WDT_UNIT_CYCLES(WD_UNIT)) cipr_regs_i (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .input_ov_det(ev_a[7]), .input_cc_act(ev_a[6]), .batt_cv_act(ev_a[5]),
    .batt_cc_act(ev_a[4]), .output_cv_act(ev_a[3]), .conn_hot(ev_a[2]),
    .batt_hot(ev_a[1]), .reverse_det(ev_a[0]), .conv_done(ev_b[6]),
    .drop_alarm_det(ev_b[5]), .drop_ov_det(ev_b[4]), .input_insert_cmp(ev_b[3]),
    .batt_insert_cmp(ev_b[2]), .die_hot(ev_b[1]), .input_oc_det(ev_b[0]),
    .uvlo_open(uvlo_open), .conn_chan_en(conn_chan_en), .batt_chan_en(batt_chan_en),
    .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .switch_close(switch_close),
    .pulldown_on(pulldown_on), .prot_enables(prot_enables), .shunt_value_sel(shunt_value_sel),
    .reverse_threshold_sel(reverse_threshold_sel), .reverse_limit_ma(reverse_limit_ma),
    .die_temp_meas_enable(die_temp_meas_enable), .adc_enable(adc_enable),
    .adc_continuous(adc_continuous));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] rst_val(input int a);
    case (a)
      5: return 8'hFE;
      6: return 8'h28;
      7: return 8'h87;
      default: return 8'h00;
    endcase
  endfunction

  function automatic int wd_cyc(input logic [1:0] code);
    return (code == 2'b00) ? 300 : WD_UNIT << (code - 2'b01);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cipr_host_model_i.rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    ev_a <= a;
    ev_b <= b;
    @(posedge clk);
    ev_a <= 8'h00;
    ev_b <= 8'h00;
    @(posedge clk);
    #1;
  endtask

  task automatic wd_try(input logic [1:0] code);
    int n;
    n = 0;
    cipr_host_model_i.wr(8'h05, 8'h00);
    cipr_host_model_i.wr(8'h06, {4'h2, code, 2'b00});
    // No access from here on, so only expiry can restore the enables
    while (prot_enables !== 8'hFE && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n > wd_cyc(code) - 5 && n <= wd_cyc(code) + 5), 16'h0001);
    rchk(8'h06, (code == 2'b00) ? 8'h20 : 8'h28);
  endtask

  task automatic tally_and_finish;
    $display("Mismatches %0d, comparisons %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0] r;
    void'($urandom(32'hE0B48D45));
    resetn = 1'b0;
    ev_a = 8'h00;
    ev_b = 8'h00;
    uvlo_open = 1'b0;
    conn_chan_en = 1'b1;
    batt_chan_en = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 9; a++) rchk(8'(a), rst_val(a));
    check({die_temp_meas_enable, adc_enable, adc_continuous, shunt_value_sel}, 16'hB);
    check(reverse_limit_ma, 16'h0064);
    // ----------------------------------------
    // Random read-back and reserved bits
    // ----------------------------------------
    repeat (4)
    begin
      r = 8'($urandom);
      cipr_host_model_i.wr(8'h05, r);
      rchk(8'h05, r);
      check({8'h00, prot_enables}, {8'h00, r});
      check({15'h0, pulldown_on}, {15'h0, r[0]});
      cipr_host_model_i.wr(8'h02, r | 8'h80);
      rchk(8'h02, r & 8'h7F);
      cipr_host_model_i.wr(8'h06, r & 8'hEE);
      rchk(8'h06, r & 8'hEE);
      check({shunt_value_sel, 15'h0}, {r[5], 15'h0});
      check(reverse_limit_ma, r[1] ? 16'h0BB8 : 16'h0064);
      check({15'h0, reverse_threshold_sel}, {15'h0, r[1]});
    end
    cipr_host_model_i.wr(8'h07, 8'hFF);
    rchk(8'h07, 8'h8F);
    cipr_host_model_i.wr(8'h02, 8'h00);
    // ----------------------------------------
    // Every flag: set, hold, clear on read
    // ----------------------------------------
    cipr_host_model_i.wr(8'h07, 8'h88);
    cipr_host_model_i.wr(8'h06, 8'hC8);
    check({13'h0, die_temp_meas_enable, adc_enable, adc_continuous}, 16'h0006);
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i, 8'h00);
      check({15'h0, irq_n_oe}, 16'h0001);
      check({15'h0, irq_n_o}, 16'h0000);
      rchk(8'h03, 8'h01 << i);
      rchk(8'h03, 8'h00);
    end
    for (int i = 0; i < 7; i++)
    begin
      pulse(8'h00, 8'h01 << i);
      rchk(8'h04, 8'h01 << i);
      rchk(8'h04, 8'h00);
    end
    // Masked flag keeps the pin released
    cipr_host_model_i.wr(8'h01, 8'h80);
    pulse(8'h80, 8'h00);
    check({15'h0, irq_n_oe}, 16'h0000);
    rchk(8'h03, 8'h80);
    // ----------------------------------------
    // Gated events stay silent
    // ----------------------------------------
    cipr_host_model_i.wr(8'h07, 8'h87);
    cipr_host_model_i.wr(8'h06, 8'h28);
    conn_chan_en <= 1'b0;
    batt_chan_en <= 1'b0;
    pulse(8'h06, 8'h7C);
    rchk(8'h03, 8'h00);
    rchk(8'h04, 8'h00);
    // ----------------------------------------
    // Pass switch clears on fault, not on undervoltage
    // ----------------------------------------
    cipr_host_model_i.wr(8'h06, 8'h38);
    uvlo_open <= 1'b1;
    pulse(8'h00, 8'h02);
    check({15'h0, switch_close}, 16'h0001);
    uvlo_open <= 1'b0;
    pulse(8'h00, 8'h02);
    check({15'h0, switch_close}, 16'h0000);
    rchk(8'h06, 8'h28);
    // ----------------------------------------
    // Soft reset: zero ignored, one restores defaults
    // ----------------------------------------
    cipr_host_model_i.wr(8'h05, 8'h00);
    cipr_host_model_i.wr(8'h01, 8'hFF);
    pulse(8'h80, 8'h00);
    cipr_host_model_i.wr(8'h06, 8'h28);
    rchk(8'h05, 8'h00);
    cipr_host_model_i.wr(8'h06, 8'h29);
    repeat (2) @(posedge clk);
    for (int a = 1; a < 8; a++) rchk(8'(a), rst_val(a));
    for (int c = 0; c < 4; c++) wd_try(2'(c));
    tally_and_finish();
  end
endmodule
